// ==== include/debug_cmd_defs.vh ====
/*
 Constants of the debug command executor: opcodes, response words,
 memory sizes, timing counts.
 Assumes inclusion by bare name from the design file.
*/
`ifndef DEBUG_CMD_DEFS_VH
`define DEBUG_CMD_DEFS_VH

// Command opcodes (16-bit command word)
`define OPC_READ_B 16'h1900
`define OPC_READ_W 16'h1940
`define OPC_READ_L 16'h1980
`define OPC_WRITE_B 16'h1800
`define OPC_WRITE_W 16'h1840
`define OPC_WRITE_L 16'h1880
`define OPC_DUMP_B 16'h1d00
`define OPC_DUMP_W 16'h1d40
`define OPC_DUMP_L 16'h1d80
`define OPC_FILL_B 16'h1c00
`define OPC_FILL_W 16'h1c40
`define OPC_FILL_L 16'h1c80
`define OPC_RESUME 16'h0c00
`define OPC_PATCH 16'h0800
`define OPC_PERIPH_RST 16'h0400
`define OPC_NOP 16'h0000
`define SIZE_LSB 6
`define SIZE_MSB 7
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

// 17-bit responses: bit 16 is the status bit
`define RESP_STATUS_BIT 16
`define RESP_DONE 17'h0ffff
`define RESP_ERROR 17'h10001
`define RESP_UNKNOWN 17'h1ffff

// Peripheral reset length
`define PRST_CYCLES 512
`define PRST_CNT_W 10
`define PRST_CNT_INIT 10'h1ff

// Reset value of the debug mode flag
`define RST_DEBUG_MODE 1'b1

`endif

// ==== src/debug_mode_command_executor.v ====
/*
 Debug command executor: takes 16-bit command words and 16-bit operand
 words from the serial shifter, runs memory, block, resume, patch and
 peripheral reset commands, and hands 17-bit answers back to the shifter.
 Assumes: a shifter clocked by clk_sys presenting words with a one-cycle
 strobe, a memory port that answers each request with done and error,
 and a core that accepts resume and patch requests and reports stacking.
*/
`timescale 1ns/100ps
`include "debug_cmd_defs.vh"

module debug_mode_command_executor (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Words from the serial shifter
	input wire cmdValid,
	input wire [15:0] cmdWord,
	// Words to the serial shifter
	output reg respValid,
	output reg [16:0] respWord,
	// Space code registers of the core
	input wire [2:0] src_space_code_reg,
	input wire [2:0] dest_space_code_reg,
	// Memory port
	output reg memReq,
	output reg memWrite,
	output reg [1:0] memSize,
	output reg [31:0] memAddr,
	output reg [31:0] memWdata,
	output reg [2:0] memSpace,
	input wire memDone,
	input wire memError,
	input wire [31:0] memRdata,
	// Core control
	output reg resumeReq,
	output reg patchReq,
	output reg [31:0] patchPc,
	input wire stackDone,
	input wire stackError,
	output reg background_debug_mode,
	input wire prefetchError,
	// External peripheral reset line
	output reg periphReset
);

	////////////////////////////////////////////////////////////////////
	// Sequencer states, one-hot
	localparam S_IDLE = 8'h01;
	localparam S_ADDR = 8'h02;
	localparam S_DATA = 8'h04;
	localparam S_MEM = 8'h08;
	localparam S_STACK = 8'h10;
	localparam S_RST = 8'h20;
	localparam S_RUN = 8'h40;
	localparam S_OPND = 8'h80;

	// Sequencer state, command in progress and its operands
	reg [7:0] state;
	reg [15:0] opcode;
	reg [1:0] words;
	reg [31:0] addr;
	reg [31:0] data;
	reg [31:0] pointer;
	reg [1:0] size;
	reg writeOp;
	reg [`PRST_CNT_W-1:0] rstCnt;
	reg fetchArmed;

	// Size in bytes of an operand size code
	function [31:0] sizeBytes;
		input [1:0] sz;
		begin
			case (sz)
				`SIZE_BYTE: sizeBytes = 32'h1;
				`SIZE_WORD: sizeBytes = 32'h2;
				default: sizeBytes = 32'h4;
			endcase
		end
	endfunction

	// Data words a size needs on the link
	function [1:0] sizeWords;
		input [1:0] sz;
		begin
			sizeWords = (sz == `SIZE_LONG) ? 2'h2 : 2'h1;
		end
	endfunction

	// Data as returned to the host
	function [16:0] readReply;
		input [1:0] sz;
		input [31:0] d;
		begin
			case (sz)
				`SIZE_BYTE: readReply = {9'h000, d[7:0]};
				default: readReply = {1'b0, d[15:0]};
			endcase
		end
	endfunction

	// Sized command of one family; size code 3 is unassigned
	function isSized;
		input [15:0] w;
		input [15:0] base;
		begin
			isSized = (w[`SIZE_MSB:`SIZE_LSB] != 2'h3) &&
				({w[15:8], 2'b00, w[5:0]} == base);
		end
	endfunction

	// Size field of the incoming word
	wire [1:0] cmdSize = cmdWord[`SIZE_MSB:`SIZE_LSB];

	////////////////////////////////////////////////////////////////////
	// Command sequencer
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			state <= S_IDLE;
			opcode <= 16'h0000;
			words <= 2'h0;
			addr <= 32'h0;
			data <= 32'h0;
			pointer <= 32'h0;
			size <= `SIZE_BYTE;
			writeOp <= 1'b0;
			rstCnt <= {`PRST_CNT_W{1'b0}};
			respValid <= 1'b0;
			respWord <= 17'h0;
			memReq <= 1'b0;
			memWrite <= 1'b0;
			memSize <= `SIZE_BYTE;
			memAddr <= 32'h0;
			memWdata <= 32'h0;
			memSpace <= 3'h0;
			resumeReq <= 1'b0;
			patchReq <= 1'b0;
			patchPc <= 32'h0;
			background_debug_mode <= `RST_DEBUG_MODE;
			fetchArmed <= 1'b0;
			periphReset <= 1'b0;
		end else begin
			// Pulses fall unless a state raises them
			respValid <= 1'b0;
			resumeReq <= 1'b0;
			patchReq <= 1'b0;
			case (state)
				S_IDLE: begin
					if (cmdValid) begin
						// Operands of the new command start clean
						opcode <= cmdWord;
						size <= cmdSize;
						words <= 2'h2;
						addr <= 32'h0;
						data <= 32'h0;
						if (isSized(cmdWord, `OPC_READ_B)) begin
							// Memory read: address words follow
							writeOp <= 1'b0;
							state <= S_ADDR;
						end else if (isSized(cmdWord, `OPC_WRITE_B)) begin
							// Memory write: address, then data
							writeOp <= 1'b1;
							state <= S_ADDR;
						end else if (isSized(cmdWord, `OPC_DUMP_B)) begin
							// Pointer is trusted as left by the last memory command
							writeOp <= 1'b0;
							addr <= pointer;
							state <= S_MEM;
							memReq <= 1'b1;
							memWrite <= 1'b0;
							memSize <= cmdSize;
							memAddr <= pointer;
							memSpace <= src_space_code_reg;
						end else if (isSized(cmdWord, `OPC_FILL_B)) begin
							// Block write: data words only
							writeOp <= 1'b1;
							addr <= pointer;
							words <= sizeWords(cmdSize);
							state <= S_DATA;
						end else if (cmdWord == `OPC_RESUME) begin
							// Resume: leave debug mode at once
							resumeReq <= 1'b1;
							background_debug_mode <= 1'b0;
							fetchArmed <= 1'b1;
							state <= S_RUN;
						end else if (cmdWord == `OPC_PATCH) begin
							// Patch call: start address follows
							state <= S_OPND;
						end else if (cmdWord == `OPC_PERIPH_RST) begin
							// Peripheral reset: start the count
							periphReset <= 1'b1;
							rstCnt <= `PRST_CNT_INIT;
							state <= S_RST;
						end else if (cmdWord == `OPC_NOP) begin
							// No-op: answer at once
							respValid <= 1'b1;
							respWord <= `RESP_DONE;
						end else begin
							// Unassigned: answered at once with the unknown-command word
							respValid <= 1'b1;
							respWord <= `RESP_UNKNOWN;
						end
					end
				end
				// Long address, most significant word first
				// Read starts at once, write waits for data
				S_ADDR: begin
					if (cmdValid) begin
						addr <= {addr[15:0], cmdWord};
						words <= words - 2'h1;
						if (words == 2'h1) begin
							if (writeOp) begin
								words <= sizeWords(size);
								state <= S_DATA;
							end else begin
								state <= S_MEM;
								memReq <= 1'b1;
								memWrite <= 1'b0;
								memSize <= size;
								memAddr <= {addr[15:0], cmdWord};
								memSpace <= src_space_code_reg;
							end
						end
					end
				end
				// Sized write data, then start the write
				S_DATA: begin
					if (cmdValid) begin
						data <= {data[15:0], cmdWord};
						words <= words - 2'h1;
						if (words == 2'h1) begin
							state <= S_MEM;
							memReq <= 1'b1;
							memWrite <= 1'b1;
							memSize <= size;
							memAddr <= addr;
							memWdata <= (size == `SIZE_BYTE) ?
								{24'h0, cmdWord[7:0]} :
								{data[15:0], cmdWord};
							memSpace <= dest_space_code_reg;
						end
					end
				end
				// Wait for the memory cycle and answer
				S_MEM: begin
					if (memDone) begin
						memReq <= 1'b0;
						state <= S_IDLE;
						respValid <= 1'b1;
						pointer <= addr + sizeBytes(size);
						if (memError)
							respWord <= `RESP_ERROR;
						else if (writeOp)
							respWord <= `RESP_DONE;
						else if (size == `SIZE_LONG)
							respWord <= {1'b0, memRdata[31:16]};
						else
							respWord <= readReply(size, memRdata);
						// Long read: low word waits for the next word in
						if (!memError && !writeOp && size == `SIZE_LONG) begin
							data <= memRdata;
							state <= S_OPND;
							opcode <= `OPC_READ_L;
						end
					end
				end
				// Patch address words, or second half of a long read
				S_OPND: begin
					if (opcode == `OPC_READ_L) begin
						// Low word once the shifter took the high one
						if (cmdValid) begin
							respValid <= 1'b1;
							respWord <= {1'b0, data[15:0]};
							opcode <= `OPC_NOP;
							state <= S_IDLE;
						end
					end else if (cmdValid) begin
						patchPc <= {patchPc[15:0], cmdWord};
						words <= words - 2'h1;
						if (words == 2'h1) begin
							patchReq <= 1'b1;
							state <= S_STACK;
						end
					end
				end
				// Core stacks the return PC
				S_STACK: begin
					if (stackError) begin
						respValid <= 1'b1;
						respWord <= `RESP_ERROR;
						state <= S_IDLE;
					end else if (stackDone) begin
						background_debug_mode <= 1'b0;
						fetchArmed <= 1'b1;
						state <= S_RUN;
					end
				end
				// Peripheral reset count
				S_RST: begin
					rstCnt <= rstCnt - {{(`PRST_CNT_W-1){1'b0}}, 1'b1};
					if (rstCnt == {`PRST_CNT_W{1'b0}}) begin
						periphReset <= 1'b0;
						respValid <= 1'b1;
						respWord <= `RESP_DONE;
						state <= S_IDLE;
					end
				end
				// Running normally; only the first prefetch can fault
				S_RUN: begin
					if (fetchArmed && prefetchError) begin
						// Core takes it as a normal exception
						background_debug_mode <= 1'b0;
						fetchArmed <= 1'b0;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

endmodule

// ==== verification/debug_cmd_props.sv ====
/* Port checker of the debug command executor.
 Bound to the executor; sees only its ports. */
`timescale 1ns/100ps
`include "debug_cmd_defs.vh"
module debug_cmd_props (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Answers and memory port
	input wire respValid,
	input wire [16:0] respWord,
	input wire [2:0] src_space_code_reg,
	input wire [2:0] dest_space_code_reg,
	input wire memReq,
	input wire memWrite,
	input wire [2:0] memSpace,
	input wire memDone,
	input wire memError,
	// Core and reset line
	input wire stackError,
	input wire background_debug_mode,
	input wire periphReset
);
reg [10:0] hiCnt;
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!reset_n);
////////////////////////////////////////////////////////////////////////////
// Cycles spent with the reset line driven
always @(posedge clk_sys)
	hiCnt <= (!reset_n || !periphReset) ? 11'h0 : hiCnt + 11'h1;
// Port relations
property p_rdsp; memReq && !memWrite |-> memSpace == src_space_code_reg;
endproperty
a_rdsp: assert property (p_rdsp) else $error("read space wrong");
property p_wrsp; memReq && memWrite |-> memSpace == dest_space_code_reg;
endproperty
a_wrsp: assert property (p_wrsp) else $error("write space wrong");
property p_rdok; memDone && !memError && !memWrite |=> respValid &&
	!respWord[16]; endproperty
a_rdok: assert property (p_rdok) else $error("read status set");
property p_rderr; memDone && memError && !memWrite |=> respValid &&
	respWord == `RESP_ERROR; endproperty
a_rderr: assert property (p_rderr) else $error("read error word");
property p_wr; memDone && memWrite |=> respValid && respWord ==
	($past(memError) ? `RESP_ERROR : `RESP_DONE); endproperty
a_wr: assert property (p_wr) else $error("write status wrong");
property p_rlen; $fell(periphReset) |-> hiCnt == `PRST_CYCLES; endproperty
a_rlen: assert property (p_rlen) else $error("reset length");
property p_rdone; $fell(periphReset) |-> ##[0:2] respValid &&
	respWord == `RESP_DONE; endproperty
a_rdone: assert property (p_rdone) else $error("no reset reply");
property p_stk; stackError |=> respValid && respWord == `RESP_ERROR &&
	background_debug_mode; endproperty
a_stk: assert property (p_stk) else $error("stacking error reply");
c_rst: cover property ($fell(periphReset));
c_stk: cover property (stackError);
c_werr: cover property (memDone && memWrite && memError);
endmodule
bind debug_mode_command_executor debug_cmd_props u_props (
	.clk_sys(clk_sys), .reset_n(reset_n), .respValid(respValid),
	.respWord(respWord), .src_space_code_reg(src_space_code_reg),
	.dest_space_code_reg(dest_space_code_reg), .memReq(memReq),
	.memWrite(memWrite), .memSpace(memSpace), .memDone(memDone),
	.memError(memError), .stackError(stackError),
	.background_debug_mode(background_debug_mode),
	.periphReset(periphReset));

// ==== verification/mem_core_model.sv ====
/* Memory and core model at the executor's far side.
 Answers after 0 to 3 cycles set by the low address bits; fails at
 addresses with bit 31 set. */
`timescale 1ns/100ps
module mem_core_model (
	// Clock and reset
	input wire clk_sys,
	input wire reset_n,
	// Memory port
	input wire memReq,
	input wire [31:0] memAddr,
	output reg memDone,
	output reg memError,
	output reg [31:0] memRdata,
	// Core side
	input wire patchReq,
	input wire stackFail,
	output reg stackDone,
	output reg stackError
);
reg served;
reg [1:0] waitCnt;
////////////////////////////////////////////////////////////////////////////
// One answer per request; read data toggles when not valid
always @(posedge clk_sys) begin
	memDone <= 1'b0;
	memError <= 1'b0;
	memRdata <= ~memRdata;
	if (!reset_n || !memReq) begin
		served <= 1'b0;
		waitCnt <= 2'h0;
	end else if (!served && waitCnt == memAddr[1:0]) begin
		memDone <= 1'b1;
		memError <= memAddr[31];
		memRdata <= ~memAddr;
		served <= 1'b1;
	end else if (!served)
		waitCnt <= waitCnt + 2'h1;
	if (!reset_n)
		memRdata <= 32'h0;
end
// Stacking answer one cycle after a patch request
always @(posedge clk_sys) begin
	stackDone <= patchReq && !stackFail && reset_n;
	stackError <= patchReq && stackFail && reset_n;
end
endmodule

// ==== verification/test_debug_mode_command_executor.sv ====
/* Bench of the debug command executor.
 Drives command words as the shifter would; memory and core are modelled. */
`timescale 1ns/100ps
`include "debug_cmd_defs.vh"
module test_debug_mode_command_executor;
reg clk_sys, reset_n, cmdValid, stackFail, prefetchError;
reg [15:0] cmdWord;
reg [2:0] srcSpace, destSpace;
reg [31:0] wa, wd;
reg [1:0] ws;
wire respValid, memReq, memWrite, memDone, memError, resumeReq;
wire patchReq, stackDone, stackError, debugMode, periphReset;
wire [1:0] memSize;
wire [16:0] respWord;
wire [31:0] memAddr, memWdata, memRdata, patchPc;
integer failures, comparisons, resumes, cyc = 0;
debug_mode_command_executor dut (
	.clk_sys(clk_sys), .reset_n(reset_n), .cmdValid(cmdValid),
	.cmdWord(cmdWord), .respValid(respValid), .respWord(respWord),
	.src_space_code_reg(srcSpace), .dest_space_code_reg(destSpace),
	.memReq(memReq), .memWrite(memWrite), .memSize(memSize),
	.memAddr(memAddr), .memWdata(memWdata), .memSpace(),
	.memDone(memDone),
	.memError(memError), .memRdata(memRdata), .resumeReq(resumeReq),
	.patchReq(patchReq), .patchPc(patchPc), .stackDone(stackDone),
	.stackError(stackError), .background_debug_mode(debugMode),
	.prefetchError(prefetchError), .periphReset(periphReset));
mem_core_model mem (
	.clk_sys(clk_sys), .reset_n(reset_n), .memReq(memReq),
	.memAddr(memAddr), .memDone(memDone), .memError(memError),
	.memRdata(memRdata), .patchReq(patchReq), .stackFail(stackFail),
	.stackDone(stackDone), .stackError(stackError));
////////////////////////////////////////////////////////////////////////////
// Clock, timeout and monitors
initial begin
	clk_sys = 0;
	forever #4 clk_sys = ~clk_sys;
end
always @(posedge clk_sys) begin
	cyc = cyc + 1;
	if (cyc == 20000) begin
		failures = failures + 1;
		end_sim;
	end
	if (memDone) ws <= memSize;
	if (memDone && memWrite) begin
		wa <= memAddr;
		wd <= memWdata;
	end
	if (resumeReq === 1'b1) resumes <= resumes + 1;
end
////////////////////////////////////////////////////////////////////////////
// Shared tasks
task end_sim;
	begin
		if (failures == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	end
endtask
task chk(input [31:0] got, input [31:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
endtask
task send(input [15:0] w);
	begin
		cmdValid = 1;
		cmdWord = w;
		@(posedge clk_sys);
		#1;
	end
endtask
task addr(input [31:0] a);
	begin send(a[31:16]); send(a[15:0]); end
endtask
// Waits a bounded time for one answer and compares it
task ans(input [16:0] e);
	integer n;
	begin
		cmdValid = 0;
		cmdWord = 16'h5a5a;
		for (n = 0; n < 700 && respValid !== 1'b1; n = n + 1)
			@(posedge clk_sys) #1;
		chk({14'h0, respValid, respWord}, {14'h0, 1'b1, e});
	end
endtask
task do_reset;
	begin
		reset_n = 0;
		repeat (6) @(posedge clk_sys);
		#1 reset_n = 1;
	end
endtask
////////////////////////////////////////////////////////////////////////////
// Scenarios
task t_read_dump;
	begin
		send(`OPC_READ_B); addr(32'h1000); ans({9'h0, 8'hff});
		chk(ws, `SIZE_BYTE);
		send(`OPC_DUMP_W); ans({1'b0, 16'heffe});
		chk(ws, `SIZE_WORD);
		send(`OPC_NOP); ans(`RESP_DONE);
		send(`OPC_DUMP_L); ans({1'b0, 16'hffff});
		chk(ws, `SIZE_LONG);
		send(`OPC_NOP); ans({1'b0, 16'heffc});
		send(`OPC_DUMP_B); ans({9'h0, 8'hf8});
		chk(ws, `SIZE_BYTE);
		send(`OPC_READ_W); addr(32'h80000002); ans(`RESP_ERROR);
	end
endtask
task t_write_fill;
	begin
		send(`OPC_WRITE_W); addr(32'h2002); send(16'h1234);
		ans(`RESP_DONE); chk(wa, 32'h2002); chk(wd & 32'hffff, 32'h1234);
		chk(ws, `SIZE_WORD);
		send(`OPC_FILL_B); send(16'h00ab); ans(`RESP_DONE);
		chk(wa, 32'h2004); chk(wd & 32'hff, 32'hab);
		chk(ws, `SIZE_BYTE);
		send(`OPC_FILL_L); send(16'hdead); send(16'hbeef); ans(`RESP_DONE);
		chk(wa, 32'h2005); chk(wd, 32'hdeadbeef);
		chk(ws, `SIZE_LONG);
		send(`OPC_WRITE_L); addr(32'h80000010); send(16'h0); send(16'h1);
		ans(`RESP_ERROR);
		send(`OPC_FILL_W); send(16'h5555); ans(`RESP_ERROR);
	end
endtask
task t_odd;
	begin
		send(16'hffff); ans(`RESP_UNKNOWN);
		send(16'h19c0); ans(`RESP_UNKNOWN);
		send(`OPC_PERIPH_RST); cmdValid = 0;
		repeat (100) @(posedge clk_sys) #1;
		chk(periphReset, 1); chk(debugMode, 1);
		ans(`RESP_DONE); chk(periphReset, 0);
		stackFail = 1; send(`OPC_PATCH); addr(32'h4000);
		ans(`RESP_ERROR); chk(debugMode, 1);
		stackFail = 0; send(`OPC_PATCH); addr(32'h4000); cmdValid = 0;
		repeat (8) @(posedge clk_sys) #1;
		chk(patchPc, 32'h4000); chk(debugMode, 0);
		prefetchError = 1;
		@(posedge clk_sys) #1;
		prefetchError = 0;
		repeat (4) @(posedge clk_sys) #1;
		chk(debugMode, 0); chk(respValid, 0);
		do_reset; resumes = 0; send(`OPC_RESUME); cmdValid = 0;
		repeat (8) @(posedge clk_sys) #1;
		chk(resumes, 1); chk(debugMode, 0);
	end
endtask
// Main sequence
initial begin
	failures = 0; comparisons = 0; resumes = 0; stackFail = 0;
	prefetchError = 0;
	reset_n = 0; cmdValid = 0; cmdWord = 16'h0;
	srcSpace = 3'h5; destSpace = 3'h6;
	do_reset;
	t_read_dump;
	t_write_fill;
	t_odd;
	end_sim;
end
endmodule
